// File: hdl/cps_pkg.sv
// Package with addresses, fields, reset values and carrier types of the sample port.
package cps_pkg;
  // Direct host addresses, offsets from the codec base address.
  localparam logic [1:0] ADR_INDEX = 2'h0;
  localparam logic [1:0] ADR_IDATA = 2'h1;
  localparam logic [1:0] ADR_STATUS = 2'h2;
  localparam logic [1:0] ADR_PIO = 2'h3;
  // Indirect register indices.
  localparam logic [4:0] IDX_LEFT_ADC = 5'h00;
  localparam logic [4:0] IDX_MODE_ID = 5'h0c;
  localparam logic [4:0] IDX_ALT_STAT = 5'h18;
  localparam logic [4:0] IDX_FMT = 5'h1c;
  localparam int EXT_FIRST_IDX = 16;
  // Field positions.
  localparam int LADC_GAIN_LSB = 0;
  localparam int LADC_MIC_BIT = 5;
  localparam int LADC_SRC_LSB = 6;
  localparam int MODE_EXT_BIT = 6;
  localparam int ALT_PO_BIT = 1;
  localparam int ALT_CO_BIT = 2;
  // Reset and fixed values.
  localparam logic [7:0] FIXED_80 = 8'h80;
  localparam logic [7:0] LADC_RST = 8'h00;
  localparam logic [7:0] LADC_WMASK = 8'hef;
  localparam logic [7:0] MODE_RST = 8'h8a;
  localparam logic [7:0] MODE_WMASK = 8'h40;
  localparam logic [7:0] FMT_RST = 8'h00;
  // Sample formats held in the format register bits 7:5.
  localparam logic [2:0] FMT_U8 = 3'h0;
  localparam logic [2:0] FMT_S16 = 3'h2;
  localparam logic [2:0] FMT_ADPCM = 3'h5;
  localparam logic [2:0] FMT_S16BE = 3'h6;
  localparam int FMT_STEREO_BIT = 4;
  localparam int FMT_SHIFT = 5;
  localparam int SAMPLE_W = 32;
  localparam int FIFO_DEPTH = 16;
  // Byte tracker states, one-hot.
  typedef enum logic [4:0] {
    TRK_B0 = 5'b0_0001,
    TRK_B1 = 5'b0_0010,
    TRK_B2 = 5'b0_0100,
    TRK_B3 = 5'b0_1000,
    TRK_DONE = 5'b1_0000
  } cps_trk_t;
  // Host bus access.
  typedef struct packed {
    logic rd;
    logic wr;
    logic [1:0] addr;
    logic [7:0] wdata;
  } cps_host_t;
  // Left ADC input control fields.
  typedef struct packed {
    logic [1:0] src;
    logic mic_boost;
    logic [3:0] gain;
  } cps_ladc_t;
endpackage

// File: hdl/cps_fifo.sv
// Parameterised valid/ready FIFO for playback samples.
`timescale 1ns/1ps
`default_nettype none
module cps_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp_ff;
  logic [AW-1:0] rp_ff;
  logic [AW:0] cnt_ff;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  // Full and empty come straight from the occupancy count; the count is one bit wider.
  assign in_ready = cnt_ff != (AW+1)'(DEPTH);
  assign out_valid = cnt_ff != '0;
  assign out_data = mem[rp_ff];
  // Storage has no reset; only pointers and the count do.
  always_ff @(posedge ref_clk)
  begin
    if (push)
      mem[wp_ff] <= in_data;
  end
  // Pointers wrap at the depth, which need not be a power of two.
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      wp_ff <= '0;
      rp_ff <= '0;
      cnt_ff <= '0;
    end
    else
    begin
      if (push)
        wp_ff <= (wp_ff == AW'(DEPTH - 1)) ? '0 : wp_ff + 1'b1;
      if (pop)
        rp_ff <= (rp_ff == AW'(DEPTH - 1)) ? '0 : rp_ff + 1'b1;
      cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule
`default_nettype wire

// File: hdl/cps_tracker.sv
// Byte tracker that walks the bytes of one sample for the given format.
`timescale 1ns/1ps
`default_nettype none
module cps_tracker (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic step,
  input wire logic restart,
  input wire logic [2:0] fmt,
  input wire logic stereo,
  output cps_pkg::cps_trk_t state,
  output logic chan_side,
  output logic byte_half
);
  import cps_pkg::*;
  cps_trk_t st_ff;
  cps_trk_t nxt_st;
  cps_trk_t last_st;
  wire wide = (fmt == FMT_S16) || (fmt == FMT_S16BE);
  wire adpcm = fmt == FMT_ADPCM;
  // Bytes per sample: 8-bit mono 1, 8-bit stereo or 16-bit mono 2, otherwise 4.
  wire [2:0] nbytes = adpcm ? 3'd4 : ((wide ? 3'd2 : 3'd1) << stereo);
  assign last_st = (nbytes == 3'd1) ? TRK_B0 : (nbytes == 3'd2) ? TRK_B1 : TRK_B3;
  // The last byte is held as a marker; done means the sample is full.
  always_comb
  begin
    nxt_st = st_ff;
    if (restart)
      nxt_st = TRK_B0;
    else if (step)
      case (st_ff)
        TRK_B0: nxt_st = (last_st == TRK_B0) ? TRK_DONE : TRK_B1;
        TRK_B1: nxt_st = (last_st == TRK_B1) ? TRK_DONE : TRK_B2;
        TRK_B2: nxt_st = TRK_B3;
        TRK_B3: nxt_st = TRK_DONE;
        TRK_DONE: nxt_st = TRK_DONE;
        default: nxt_st = TRK_B0;
      endcase
  end
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      st_ff <= TRK_B0;
    else
      st_ff <= nxt_st;
  end
  // Done reports the last byte, so status keeps pointing at it.
  wire [4:0] eff = (st_ff == TRK_DONE) ? last_st : st_ff;
  wire is_b0 = eff[0];
  wire is_b1 = eff[1];
  wire is_b2 = eff[2];
  assign state = st_ff;
  // In 8-bit formats each byte is a channel; otherwise two bytes per half.
  assign chan_side = (!wide && !adpcm) ? is_b0 : (is_b0 || is_b1);
  assign byte_half = (!wide && !adpcm) ? 1'b1 : (is_b1 || eff[3]) ^ (is_b2 & 1'b0);
endmodule
`default_nettype wire

// File: hdl/cps_port.sv
// Programmed-I/O sample port: status, data port, index/data access and left ADC control.
//
// Operation
// (RULE1) Playback channel bit: 1 left/first half.
// (RULE2) Capture channel bit: 1 left/first half.
// (RULE3) Playback byte bit: 1 upper or 8-bit.
// (RULE4) Capture byte bit locates available byte.
// (RULE5) Sample error on overrun or underrun.
// (RULE6) Capture ready means fresh capture data.
// (RULE7) Ready bits read one when action needed.
// (RULE8) Data address: write playback, read capture.
// (RULE9) Status reads 80h while initializing.
// (RULE10) Capture data reads 80h while initializing.
// (RULE11) Capture read advances byte tracker.
// (RULE12) Capture tracker holds last byte until new; data reads return byte 3 once done, the last byte only in 4-byte formats.
// (RULE13) Status read plus new sample restarts capture.
// (RULE14) Playback write advances byte tracker.
// (RULE15) Writes after full sample ignored.
// (RULE16) Status read resets tracker, sample queued.
// (RULE17) Host writes index, then accesses data.
// (RULE18) Host writes reserved bits as zero.
// (RULE19) Indices 16-31 need extended mode bit.
// (RULE20) Four-bit left ADC gain, 1.5 dB steps.
// (RULE21) Two-bit left ADC source select.
// (RULE22) Mic boost bit enables 20 dB stage.
// (RULE23) Alternate status separates overrun, underrun.
`timescale 1ns/1ps
`default_nettype none
module cps_port #(
  parameter int FIFO_W = cps_pkg::SAMPLE_W,
  parameter int FIFO_D = cps_pkg::FIFO_DEPTH
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire cps_pkg::cps_host_t host,
  output logic [7:0] host_rdata,
  input wire logic init_busy,
  input wire logic play_en,
  input wire logic cap_en,
  output logic play_valid,
  input wire logic play_take,
  output logic [31:0] play_sample,
  input wire logic dac_underrun,
  input wire logic cap_valid,
  output logic cap_take,
  input wire logic [31:0] cap_sample,
  output cps_pkg::cps_ladc_t left_adc,
  output logic [2:0] fmt_sel,
  output logic stereo_sel
);
  import cps_pkg::*;
  ////////////////////////////////////////////////////////////////////////////
  // Registers.
  logic [4:0] index_ff;
  logic [7:0] ladc_ff;
  logic [7:0] mode_ff;
  logic [7:0] fmt_ff;
  logic [31:0] cap_hold_ff;
  logic cap_fresh_ff;
  logic cap_pend_ff;
  logic stat_seen_ff;
  logic ply_seen_ff;
  logic [31:0] play_asm_ff;
  logic over_ff;
  logic under_ff;
  logic [7:0] rdata_ff;
  logic play_valid_ff;
  logic [31:0] play_sample_ff;
  logic cap_take_ff;
  cps_trk_t cap_st;
  cps_trk_t ply_st;
  logic cap_side;
  logic cap_half;
  logic ply_side;
  logic ply_half;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [FIFO_W-1:0] fifo_out_data;
  ////////////////////////////////////////////////////////////////////////////
  // Address decode.
  wire ext_on = mode_ff[MODE_EXT_BIT];
  wire idx_ok = ext_on || (32'(index_ff) < EXT_FIRST_IDX); // RULE19
  wire wr_index = host.wr && host.addr == ADR_INDEX;
  wire wr_idata = host.wr && host.addr == ADR_IDATA && idx_ok && !init_busy;
  wire rd_status = host.rd && host.addr == ADR_STATUS;
  wire rd_pio = host.rd && host.addr == ADR_PIO && !init_busy; // RULE10
  wire wr_pio = host.wr && host.addr == ADR_PIO && !init_busy; // RULE8
  wire ply_full = ply_st == TRK_DONE;
  wire ply_accept = wr_pio && !ply_full; // RULE15
  wire cap_new = cap_valid && !cap_pend_ff;
  // Restarting on a status read waits until a new sample has arrived.
  wire cap_restart = cap_new && (stat_seen_ff || rd_status); // RULE13
  wire ply_commit = ply_full && ply_seen_ff && fifo_in_ready; // RULE16
  ////////////////////////////////////////////////////////////////////////////
  // Byte trackers, one per direction.
  cps_tracker u_cap_trk (
    .ref_clk(ref_clk),
    .rst(rst),
    .step(rd_pio), // RULE11
    .restart(cap_restart),
    .fmt(fmt_ff[7:FMT_SHIFT]),
    .stereo(fmt_ff[FMT_STEREO_BIT]),
    .state(cap_st),
    .chan_side(cap_side),
    .byte_half(cap_half)
  );
  cps_tracker u_ply_trk (
    .ref_clk(ref_clk),
    .rst(rst),
    .step(ply_accept), // RULE14
    .restart(ply_commit),
    .fmt(fmt_ff[7:FMT_SHIFT]),
    .stereo(fmt_ff[FMT_STEREO_BIT]),
    .state(ply_st),
    .chan_side(ply_side),
    .byte_half(ply_half)
  );
  cps_fifo #(
    .WIDTH(FIFO_W),
    .DEPTH(FIFO_D)
  ) u_fifo (
    .ref_clk(ref_clk),
    .rst(rst),
    .in_valid(ply_commit),
    .in_ready(fifo_in_ready),
    .in_data(FIFO_W'(play_asm_ff)),
    .out_valid(fifo_out_valid),
    .out_ready(play_take && play_valid_ff),
    .out_data(fifo_out_data)
  );
  ////////////////////////////////////////////////////////////////////////////
  // Status byte: ready bits read one when the host has work to do.
  wire play_rdy = !ply_full; // RULE7
  wire serr = over_ff || under_ff; // RULE5
  wire [7:0] status_val = {cap_half, cap_side, cap_fresh_ff, serr, // RULE2 RULE4 RULE6
                           ply_half, ply_side, 1'b0, play_rdy}; // RULE1 RULE3
  wire [7:0] status_rd = init_busy ? FIXED_80 : status_val; // RULE9
  // Byte of the held capture sample picked by the tracker state.
  wire [1:0] cap_sel = cap_st[1] ? 2'd1 : cap_st[2] ? 2'd2 :
                       (cap_st[3] || cap_st[4]) ? 2'd3 : 2'd0;
  wire [7:0] cap_byte = init_busy ? FIXED_80 : cap_hold_ff[8*cap_sel +: 8]; // RULE10
  wire [7:0] alt_val = {5'h00, over_ff, under_ff, 1'b0}; // RULE23
  wire [7:0] idata_val = !idx_ok ? 8'h00 :
                         (index_ff == IDX_LEFT_ADC) ? ladc_ff :
                         (index_ff == IDX_MODE_ID) ? mode_ff :
                         (index_ff == IDX_ALT_STAT) ? alt_val :
                         (index_ff == IDX_FMT) ? fmt_ff : 8'h00;
  wire [7:0] nxt_rdata = (host.addr == ADR_INDEX) ? {3'h0, index_ff} :
                         (host.addr == ADR_IDATA) ? idata_val :
                         (host.addr == ADR_STATUS) ? status_rd : cap_byte; // RULE8
  // Playback byte lane selected by the tracker; 8-bit stereo uses lanes 0 and 1.
  wire [1:0] ply_sel = ply_st[1] ? 2'd1 : ply_st[2] ? 2'd2 : ply_st[3] ? 2'd3 : 2'd0;
  ////////////////////////////////////////////////////////////////////////////
  // Index and indirect registers; reserved bits are masked on write.
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      index_ff <= '0;
      ladc_ff <= LADC_RST;
      mode_ff <= MODE_RST;
      fmt_ff <= FMT_RST;
    end
    else
    begin
      if (wr_index)
        index_ff <= host.wdata[4:0]; // RULE17
      if (wr_idata && index_ff == IDX_LEFT_ADC)
        ladc_ff <= host.wdata & LADC_WMASK; // RULE20 RULE21 RULE22
      if (wr_idata && index_ff == IDX_MODE_ID)
        mode_ff <= (mode_ff & ~MODE_WMASK) | (host.wdata & MODE_WMASK);
      if (wr_idata && index_ff == IDX_FMT)
        fmt_ff <= host.wdata & 8'hf0;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Capture path: one sample held; fresh until a data read made after its last byte has been read.
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      cap_hold_ff <= '0;
      cap_fresh_ff <= 1'b0;
      cap_pend_ff <= 1'b0;
      stat_seen_ff <= 1'b0;
      cap_take_ff <= 1'b0;
    end
    else
    begin
      cap_take_ff <= cap_new;
      cap_pend_ff <= cap_valid && !cap_pend_ff ? 1'b1 : (cap_valid ? cap_pend_ff : 1'b0);
      if (cap_restart)
      begin
        cap_hold_ff <= cap_sample;
        cap_fresh_ff <= 1'b1;
      end
      else if (rd_pio && cap_st == TRK_DONE)
        cap_fresh_ff <= 1'b0; // RULE6 RULE12
      if (rd_status)
        stat_seen_ff <= 1'b1;
      else if (cap_restart)
        stat_seen_ff <= 1'b0;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Playback assembly and error flags; setting wins over a clear.
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      play_asm_ff <= '0;
      over_ff <= 1'b0;
      under_ff <= 1'b0;
      ply_seen_ff <= 1'b0;
    end
    else
    begin
      if (ply_accept)
        play_asm_ff[8*ply_sel +: 8] <= host.wdata; // RULE14
      // Only a status read made while the sample is full may release it, so an
      // early poll cannot push a half-written sample or reopen the port.
      if (ply_commit)
        ply_seen_ff <= 1'b0;
      else if (rd_status && ply_full)
        ply_seen_ff <= 1'b1; // RULE16
      // Reading status clears errors, but a new error the same cycle stays.
      // A new sample over an unread fresh one is an overrun even when it replaces it.
      if (cap_en && cap_new && cap_fresh_ff)
        over_ff <= 1'b1; // RULE5
      else if (rd_status)
        over_ff <= 1'b0;
      if (play_en && dac_underrun)
        under_ff <= 1'b1; // RULE5
      else if (rd_status)
        under_ff <= 1'b0;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Registered outputs.
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      rdata_ff <= '0;
      play_valid_ff <= 1'b0;
      play_sample_ff <= '0;
    end
    else
    begin
      if (host.rd)
        rdata_ff <= nxt_rdata;
      if (!play_valid_ff || play_take)
      begin
        play_valid_ff <= fifo_out_valid && !(play_valid_ff && play_take);
        play_sample_ff <= 32'(fifo_out_data);
      end
    end
  end
  assign host_rdata = rdata_ff;
  assign play_valid = play_valid_ff;
  assign play_sample = play_sample_ff;
  assign cap_take = cap_take_ff;
  assign left_adc = cps_ladc_t'({ladc_ff[7:5], ladc_ff[3:0]});
  assign fmt_sel = fmt_ff[7:FMT_SHIFT];
  assign stereo_sel = fmt_ff[FMT_STEREO_BIT];
endmodule
`default_nettype wire

// File: sim/cps_port_sva.sv
// Port assertions for the sample port.
`timescale 1ns/1ps
`default_nettype none
module cps_port_sva
  import cps_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire cps_pkg::cps_host_t host,
  input wire logic [7:0] host_rdata,
  input wire logic init_busy,
  input wire logic play_en,
  input wire logic cap_en,
  input wire logic play_valid,
  input wire logic play_take,
  input wire logic [31:0] play_sample,
  input wire logic dac_underrun,
  input wire logic cap_valid,
  input wire logic cap_take,
  input wire cps_pkg::cps_ladc_t left_adc,
  input wire logic [2:0] fmt_sel
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  ////////////////////////////////////////
  logic [4:0] idx_ff;
  logic ext_ff;
  logic err_ff;
  logic [7:0] wd_ff;
  logic st_rd;
  logic dat_wr;
  // Access decodes, status reads in init excluded.
  assign st_rd = host.rd && host.addr == ADR_STATUS && !init_busy;
  assign dat_wr = host.wr && host.addr == ADR_IDATA && !init_busy;
  // Shadows; a new underrun wins over the clearing status read.
  always_ff @(posedge ref_clk)
  begin
    wd_ff <= host.wdata;
    err_ff <= !rst && ((dac_underrun && play_en) ||
      (err_ff && !(host.rd && host.addr == ADR_STATUS)));
    ext_ff <= !rst && ((dat_wr && idx_ff == IDX_MODE_ID) ? host.wdata[MODE_EXT_BIT] : ext_ff);
    if (rst)
      idx_ff <= '0;
    else if (host.wr && host.addr == ADR_INDEX)
      idx_ff <= host.wdata[4:0];
  end
  ////////////////////////////////////////
  chk_init_status:
    assert property (host.rd && host.addr == ADR_STATUS && init_busy |=> host_rdata == FIXED_80)
    else $error("status not 80h in init");
  chk_init_capture:
    assert property (host.rd && host.addr == ADR_PIO && init_busy |=> host_rdata == FIXED_80)
    else $error("capture not 80h in init");
  chk_rdata_hold:
    assert property (!host.rd |=> $stable(host_rdata))
    else $error("read data moved without read");
  chk_left_adc_fields:
    assert property (dat_wr && idx_ff == IDX_LEFT_ADC |=> left_adc == {wd_ff[7:5], wd_ff[3:0]})
    else $error("left adc fields wrong");
  chk_ext_read_gate:
    assert property (host.rd && host.addr == ADR_IDATA && idx_ff[4] && !ext_ff
      |=> host_rdata == 8'h00)
    else $error("extended index readable");
  chk_ext_write_gate:
    assert property (dat_wr && idx_ff == IDX_FMT && !ext_ff |=> $stable(fmt_sel))
    else $error("format written without mode");
  chk_cap_ack:
    assert property (cap_take |-> $past(cap_valid) ##1 !cap_take)
    else $error("bad capture acknowledge");
  chk_play_hold:
    assert property (play_valid && !play_take |=> play_valid && $stable(play_sample))
    else $error("playback sample dropped");
  chk_err_set:
    assert property (st_rd && err_ff |=> host_rdata[4])
    else $error("error flag missing");
  chk_err_clear:
    assert property (st_rd && !err_ff && !cap_en |=> !host_rdata[4])
    else $error("error flag spurious");
  cov_cap_load: cover property (cap_take);
  cov_play_out: cover property (play_valid && play_take);
  cov_err_read: cover property (st_rd && err_ff);
endmodule
bind cps_port cps_port_sva u_sva (.ref_clk(ref_clk), .rst(rst), .host(host),
  .host_rdata(host_rdata), .init_busy(init_busy), .play_en(play_en), .cap_en(cap_en),
  .play_valid(play_valid), .play_take(play_take), .play_sample(play_sample),
  .dac_underrun(dac_underrun), .cap_valid(cap_valid), .cap_take(cap_take),
  .left_adc(left_adc), .fmt_sel(fmt_sel));
`default_nettype wire

// File: sim/cps_conv_model.sv
// Converter side model: DAC sink with optional stall, ADC sample source.
`timescale 1ns/1ps
`default_nettype none
module cps_conv_model (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic slow,
  input wire logic offer,
  input wire logic [31:0] offer_data,
  output logic play_take,
  input wire logic cap_take,
  output logic cap_valid,
  output logic [31:0] cap_sample
);
  // Idle data toggles so a stale sample never looks valid by chance.
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      play_take <= 1'b0;
      cap_valid <= 1'b0;
      cap_sample <= 32'h0000_0000;
    end
    else
    begin
      play_take <= !slow || !play_take;
      if (offer && !cap_valid)
      begin
        cap_valid <= 1'b1;
        cap_sample <= offer_data;
      end
      else
      begin
        if (cap_take)
          cap_valid <= 1'b0;
        if (cap_take || !cap_valid)
          cap_sample <= ~cap_sample;
      end
    end
  end
endmodule
`default_nettype wire

// File: sim/codec_pio_sample_port_tb.sv
// Self-checking testbench of the sample port.
`timescale 1ns/1ps
`default_nettype none
module codec_pio_sample_port_tb;
  import cps_pkg::*;
  logic ref_clk, rst, init_busy, play_en, cap_en, play_valid, play_take, dac_underrun;
  logic cap_valid, cap_take, stereo_sel, slow, offer, rd_pend;
  logic [7:0] host_rdata, d;
  logic [2:0] fmt_sel;
  logic [31:0] play_sample, cap_sample, offer_data, smp;
  cps_host_t host;
  cps_ladc_t left_adc;
  int bad_count, checked;
  logic [7:0] exp_q[$], msk_q[$];
  logic [31:0] pexp_q[$];
  logic [7:0] stat_tab[5] = '{8'he0, 8'h20, 8'ha0, 8'ha0, 8'h80};
  ////////////////////////////////////////
  cps_port #(.FIFO_W(SAMPLE_W), .FIFO_D(FIFO_DEPTH)) dut (.ref_clk(ref_clk), .rst(rst),
    .host(host), .host_rdata(host_rdata), .init_busy(init_busy), .play_en(play_en),
    .cap_en(cap_en), .play_valid(play_valid), .play_take(play_take),
    .play_sample(play_sample), .dac_underrun(dac_underrun), .cap_valid(cap_valid),
    .cap_take(cap_take), .cap_sample(cap_sample), .left_adc(left_adc),
    .fmt_sel(fmt_sel), .stereo_sel(stereo_sel));
  cps_conv_model u_conv (.ref_clk(ref_clk), .rst(rst), .slow(slow), .offer(offer),
    .offer_data(offer_data), .play_take(play_take), .cap_take(cap_take),
    .cap_valid(cap_valid), .cap_sample(cap_sample));
  ////////////////////////////////////////
  // Clock, and a watchdog that cuts a hang short.
  initial
  begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    bad_count++;
    conclude();
  end
  task automatic conclude();
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic cmp8(string what, logic [7:0] e, logic [7:0] g);
    checked++;
    if (g !== e)
    begin
      $display("unexpected %s expected %h seen %h", what, e, g);
      bad_count++;
    end
  endtask
  task automatic cmp32(string what, logic [31:0] e, logic [31:0] g);
    checked++;
    if (g !== e)
    begin
      $display("unexpected %s expected %h seen %h", what, e, g);
      bad_count++;
    end
  endtask
  ////////////////////////////////////////
  // One host pulse per call, with an idle cycle after it.
  task automatic acc(logic r, logic w, logic [1:0] a, logic [7:0] v);
    @(negedge ref_clk);
    host = '{rd: r, wr: w, addr: a, wdata: v};
    @(negedge ref_clk);
    host = '0;
  endtask
  task automatic rd_chk(logic [1:0] a, logic [7:0] e, logic [7:0] m);
    exp_q.push_back(e & m);
    msk_q.push_back(m);
    acc(1'b0 | 1'b1, 1'b0, a, 8'h00);
  endtask
  task automatic ireg_wr(logic [4:0] i, logic [7:0] v);
    acc(1'b0, 1'b1, ADR_INDEX, {3'h0, i});
    acc(1'b0, 1'b1, ADR_IDATA, v);
  endtask
  task automatic ireg_rd(logic [4:0] i, logic [7:0] e, logic [7:0] m);
    acc(1'b0, 1'b1, ADR_INDEX, {3'h0, i});
    rd_chk(ADR_IDATA, e, m);
  endtask
  task automatic offer_cap(logic [31:0] v);
    int n;
    @(negedge ref_clk);
    offer = 1'b1;
    offer_data = v;
    @(negedge ref_clk);
    offer = 1'b0;
    for (n = 0; n < 50 && cap_take !== 1'b1; n++)
      @(negedge ref_clk);
    if (n == 50)
    begin
      bad_count++;
      conclude();
    end
  endtask
  // Results are matched against the oldest note when they appear.
  always @(posedge ref_clk)
  begin
    if (rd_pend === 1'b1)
      cmp8("host_rdata", exp_q.pop_front(), host_rdata & msk_q.pop_front());
    if (play_valid === 1'b1 && play_take === 1'b1 && !rst)
      cmp32("play_sample", pexp_q.size() > 0 ? pexp_q.pop_front() : 32'hxxxx_xxxx,
        play_sample);
    rd_pend = host.rd && !rst;
  end
  ////////////////////////////////////////
  // Main sequence.
  initial
  begin
    void'($urandom(15));
    host = '0;
    {init_busy, rst} = 2'b11;
    {play_en, cap_en, dac_underrun, slow, offer} = 5'h00;
    offer_data = 32'h0000_0000;
    repeat (16) @(posedge ref_clk);
    @(negedge ref_clk);
    rst = 1'b0;
    rd_chk(ADR_STATUS, FIXED_80, 8'hff);
    rd_chk(ADR_PIO, FIXED_80, 8'hff);
    acc(1'b0, 1'b1, ADR_PIO, 8'h5a);
    init_busy = 1'b0;
    rd_chk(ADR_STATUS, 8'h0d, 8'h3f);
    ireg_rd(IDX_LEFT_ADC, LADC_RST, 8'hef);
    ireg_rd(IDX_MODE_ID, MODE_RST, 8'hff);
    for (int i = 0; i < 4; i++)
    begin
      d = {i[1:0], 6'($urandom)} & LADC_WMASK;
      ireg_wr(IDX_LEFT_ADC, d);
      cmp8("left_adc", {1'b0, d[7:5], d[3:0]}, {1'b0, left_adc});
      ireg_rd(IDX_LEFT_ADC, d, 8'hef);
    end
    ireg_wr(IDX_FMT, 8'h50);
    ireg_rd(IDX_FMT, 8'h00, 8'hff);
    ireg_wr(IDX_MODE_ID, 8'h40);
    ireg_rd(IDX_MODE_ID, MODE_RST | 8'h40, 8'hff);
    ireg_wr(IDX_FMT, 8'h50);
    cmp8("format", {4'h0, FMT_S16, 1'b1}, {4'h0, fmt_sel, stereo_sel});
    rd_chk(ADR_STATUS, 8'h05, 8'h0f);
    play_en = 1'b1;
    for (int k = 0; k < 2; k++)
    begin
      slow = k[0];
      smp = $urandom;
      pexp_q.push_back(smp);
      for (int b = 0; b < 4; b++)
        acc(1'b0, 1'b1, ADR_PIO, smp[8*b +: 8]);
      acc(1'b0, 1'b1, ADR_PIO, ~smp[7:0]);
      rd_chk(ADR_STATUS, 8'h00, 8'h01);
      rd_chk(ADR_STATUS, 8'h05, 8'h0f);
    end
    acc(1'b0, 1'b1, ADR_INDEX, {3'h0, IDX_ALT_STAT});
    dac_underrun = 1'b1;
    @(negedge ref_clk);
    dac_underrun = 1'b0;
    rd_chk(ADR_IDATA, 8'h02, 8'h06);
    rd_chk(ADR_STATUS, 8'h10, 8'h10);
    rd_chk(ADR_STATUS, 8'h00, 8'h10);
    cap_en = 1'b1;
    smp = $urandom;
    offer_cap(smp);
    rd_chk(ADR_STATUS, 8'h60, 8'he0);
    for (int b = 0; b < 5; b++)
    begin
      rd_chk(ADR_PIO, smp[8*(b > 3 ? 3 : b) +: 8], 8'hff);
      rd_chk(ADR_STATUS, stat_tab[b], 8'he0);
    end
    offer_cap(~smp);
    rd_chk(ADR_STATUS, 8'h60, 8'hf0);
    offer_cap(smp ^ 32'h5a5a_5a5a);
    rd_chk(ADR_IDATA, 8'h04, 8'h04);
    rd_chk(ADR_STATUS, 8'h10, 8'h10);
    for (int n = 0; n < 200 && pexp_q.size() > 0; n++)
      @(negedge ref_clk);
    repeat (2) @(negedge ref_clk);
    if (pexp_q.size() > 0)
      bad_count++;
    conclude();
  end
endmodule
`default_nettype wire
